/* rtl/watchdog_defs.vh */
// Purpose: constants for the 24-bit watchdog timer
// Assumes: 200 MHz system clock, 10 kHz watchdog tick derived by divider
// Notes:   offsets are byte addresses of 8-bit registers
`ifndef WATCHDOG_DEFS_VH
`define WATCHDOG_DEFS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define WDG_ADDR_CONTROL     12'h0FF0
`define WDG_ADDR_UPPER      12'h0FF1
`define WDG_ADDR_HIGH       12'h0FF2
`define WDG_ADDR_LOW        12'h0FF3
`define WDG_ADDR_CONFIG     12'h0FF4
`define WDG_ADDR_IRQ_STATUS 12'h0FF5
`define WDG_ADDR_IRQ_MASK   12'h0FF6
`define WDG_ADDR_COUNT_U    12'h0FF7

// ----------------------------------------------------------------
// fields and values
// ----------------------------------------------------------------
`define WDG_KEY_FIRST       8'h55
`define WDG_KEY_SECOND      8'hAA
`define WDG_RELOAD_RESET    24'h00_0400
`define WDG_NO_REFRESH_MAX  24'h00_0002
`define WDG_CFG_IRQ_BIT     0
`define WDG_RST_STAT_WDT    0
`define WDG_IRQ_TIMEOUT_BIT 0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define WDG_CLK_HZ          200000000
`define WDG_TICK_HZ         10000
`define WDG_TICK_CYCLES     (`WDG_CLK_HZ / `WDG_TICK_HZ)

`endif

/* rtl/wdg_tick_divider.v */
// Purpose: one-cycle enable pulse at the watchdog tick rate
// Assumes: single system clock
// Notes:   runs only while enabled so the first tick is a full period
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_defs.vh"
module wdg_tick_divider #(
   parameter integer DIVIDE = `WDG_TICK_CYCLES
) (
   // clock and reset
   input  wire       clk_sys_i,
   input  wire       rst_i,
   // control
   input  wire       run_i,
   output reg        tick_o
);
   reg  [15:0] div_reg;

   // ----------------------------------------------------------------
   // divider
   // ----------------------------------------------------------------
   // restart from zero when stopped to keep period honest
   always @(posedge clk_sys_i) begin
      if (rst_i || !run_i) begin
         div_reg <= 16'h0000;
         tick_o  <= 1'b0;
      end else if (div_reg == DIVIDE[15:0] - 16'h0001) begin
         div_reg <= 16'h0000;
         tick_o  <= 1'b1;
      end else begin
         div_reg <= div_reg + 16'h0001;
         tick_o  <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* rtl/wdg_unlock_fsm.v */
// Purpose: tracks the two-byte unlock sequence for reload registers
// Assumes: control-address writes flagged by ctl_wr_i
// Notes:   any wrong byte restarts the sequence
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_defs.vh"
module wdg_unlock_fsm (
   // clock and reset
   input  wire       clk_sys_i,
   input  wire       rst_i,
   // events
   input  wire       ctl_wr_i,
   input  wire [7:0] ctl_data_i,
   input  wire       reload_wr_i,
   output wire       unlocked_o
);
   localparam [1:0] ST_LOCKED = 2'b00;
   localparam [1:0] ST_HALF   = 2'b01;
   localparam [1:0] ST_OPEN   = 2'b10;

   reg  [1:0] state_reg;
   reg  [1:0] state_next;

   // ----------------------------------------------------------------
   // sequence
   // ----------------------------------------------------------------
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_LOCKED: begin
            if (ctl_wr_i && ctl_data_i == `WDG_KEY_FIRST)
               state_next = ST_HALF;
         end
         ST_HALF: begin
            if (ctl_wr_i)
               state_next = (ctl_data_i == `WDG_KEY_SECOND) ? ST_OPEN : ST_LOCKED;
         end
         ST_OPEN: begin
            // relock once the low byte closes the write sequence
            if (reload_wr_i)
               state_next = ST_LOCKED;
            else if (ctl_wr_i)
               state_next = (ctl_data_i == `WDG_KEY_FIRST) ? ST_HALF : ST_LOCKED;
         end
         default: state_next = ST_LOCKED;
      endcase
   end

   always @(posedge clk_sys_i) begin
      if (rst_i)
         state_reg <= ST_LOCKED;
      else
         state_reg <= state_next;
   end

   assign unlocked_o = (state_reg == ST_OPEN);
endmodule
`default_nettype wire

/* rtl/watchdog_timer_24bit.v */
// Purpose: 24-bit watchdog with lockable reload and reset/irq response
// Assumes: register port single-cycle, read data valid one cycle later
// Notes:   reload bytes writable only after unlock; low byte relocks
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_defs.vh"
module watchdog_timer_24bit #(
   parameter integer TICK_DIVIDE = `WDG_TICK_CYCLES
) (
   // clock and reset
   input  wire        clk_sys_i,
   input  wire        rst_i,
   // register port
   input  wire [11:0] addr_i,
   input  wire [7:0]  wdata_i,
   input  wire        wr_i,
   input  wire        rd_i,
   output reg  [7:0]  rdata_o,
   // device side
   input  wire        refresh_i,
   input  wire        always_on_option_bit_i,
   output reg         wdt_reset_o,
   output wire        irq_o,
   output wire        running_o
);
   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   reg  [7:0]  reload_upper_byte_reg;
   reg  [7:0]  reload_high_byte_reg;
   reg  [7:0]  reload_low_byte_reg;
   reg  [23:0] count_reg;
   reg         on_reg;
   reg         cfg_irq_reg;
   reg         irq_stat_reg;
   reg         irq_mask_reg;
   reg         rst_stat_reg;
   reg         ao_seen_reg;
   wire        tick;
   wire        unlocked;
   wire        terminal;
   wire [23:0] reload_val;
   wire        ctl_wr;
   wire        reload_wr_ok;
   wire        can_refresh;

   // reset reload held as a sized vector so each byte is a clean part-select
   localparam [23:0] RELOAD_RESET = `WDG_RELOAD_RESET;

   // address match used by the write decoders; the read path uses a case
   function hit;
      input [11:0] a;
      input [11:0] target;
      begin
         hit = (a == target);
      end
   endfunction

   assign ctl_wr       = wr_i && hit(addr_i, `WDG_ADDR_CONTROL);
   assign reload_wr_ok = wr_i && unlocked;
   assign reload_val   = {reload_upper_byte_reg, reload_high_byte_reg, reload_low_byte_reg};
   assign terminal     = on_reg && tick && (count_reg == 24'h00_0001);
   // near the end a refresh would race the response, so it is refused
   assign can_refresh  = count_reg > `WDG_NO_REFRESH_MAX;
   assign running_o    = on_reg;

   // ----------------------------------------------------------------
   // submodules
   // ----------------------------------------------------------------
   wdg_tick_divider #(
      .DIVIDE(TICK_DIVIDE)
   ) u_div (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .run_i     (on_reg),
      .tick_o    (tick)
   );

   wdg_unlock_fsm u_lock (
      .clk_sys_i   (clk_sys_i),
      .rst_i       (rst_i),
      .ctl_wr_i    (ctl_wr),
      .ctl_data_i  (wdata_i),
      .reload_wr_i (wr_i && unlocked && hit(addr_i, `WDG_ADDR_LOW)),
      .unlocked_o  (unlocked)
   );

   // ----------------------------------------------------------------
   // reload bytes
   // ----------------------------------------------------------------
   // unlock writes touch nothing here; control writes store no bits
   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         reload_upper_byte_reg <= RELOAD_RESET[23:16];
         reload_high_byte_reg  <= RELOAD_RESET[15:8];
         reload_low_byte_reg   <= RELOAD_RESET[7:0];
      end else if (reload_wr_ok) begin
         if (hit(addr_i, `WDG_ADDR_UPPER))
            reload_upper_byte_reg <= wdata_i;
         if (hit(addr_i, `WDG_ADDR_HIGH))
            reload_high_byte_reg <= wdata_i;
         if (hit(addr_i, `WDG_ADDR_LOW))
            reload_low_byte_reg <= wdata_i;
      end
   end

   // ----------------------------------------------------------------
   // on/off state and counter
   // ----------------------------------------------------------------
   // option bit caught by a clocked process in the first cycle after reset
   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         on_reg      <= 1'b0;
         ao_seen_reg <= 1'b0;
         count_reg   <= `WDG_RELOAD_RESET;
      end else begin
         ao_seen_reg <= 1'b1;
         if (!ao_seen_reg && always_on_option_bit_i) begin
            on_reg    <= 1'b1;
            count_reg <= reload_val;
         end else if (refresh_i && (!on_reg || can_refresh)) begin
            on_reg    <= 1'b1;
            count_reg <= reload_val;
         end else if (terminal) begin
            // both modes keep running from the reload value
            count_reg <= reload_val;
         end else if (on_reg && tick) begin
            count_reg <= count_reg - 24'h00_0001;
         end
      end
   end

   // ----------------------------------------------------------------
   // time-out response
   // ----------------------------------------------------------------
   // reset pulse is one cycle; system reset logic stretches it
   always @(posedge clk_sys_i) begin
      if (rst_i)
         wdt_reset_o <= 1'b0;
      else
         wdt_reset_o <= terminal && !cfg_irq_reg;
   end

   // ----------------------------------------------------------------
   // config, status and interrupt
   // ----------------------------------------------------------------
   // set wins over write-one-to-clear in the same cycle
   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         cfg_irq_reg  <= 1'b0;
         irq_mask_reg <= 1'b0;
         irq_stat_reg <= 1'b0;
      end else begin
         if (wr_i && hit(addr_i, `WDG_ADDR_CONFIG))
            cfg_irq_reg <= wdata_i[`WDG_CFG_IRQ_BIT];
         if (wr_i && hit(addr_i, `WDG_ADDR_IRQ_MASK))
            irq_mask_reg <= wdata_i[`WDG_IRQ_TIMEOUT_BIT];
         if (terminal && cfg_irq_reg)
            irq_stat_reg <= 1'b1;
         else if (wr_i && hit(addr_i, `WDG_ADDR_IRQ_STATUS) && wdata_i[`WDG_IRQ_TIMEOUT_BIT])
            irq_stat_reg <= 1'b0;
      end
   end

   assign irq_o = irq_stat_reg && irq_mask_reg;

   // reset status survives our own reset pulse; cleared on read of control
   always @(posedge clk_sys_i) begin
      if (rst_i)
         rst_stat_reg <= 1'b0;
      else if (terminal && !cfg_irq_reg)
         rst_stat_reg <= 1'b1;
      else if (rd_i && hit(addr_i, `WDG_ADDR_CONTROL))
         rst_stat_reg <= 1'b0;
   end

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   always @(posedge clk_sys_i) begin
      if (rst_i)
         rdata_o <= 8'h00;
      else if (rd_i) begin
         case (addr_i)
            `WDG_ADDR_CONTROL:    rdata_o <= {7'h00, rst_stat_reg};
            `WDG_ADDR_UPPER:      rdata_o <= reload_upper_byte_reg;
            `WDG_ADDR_HIGH:       rdata_o <= reload_high_byte_reg;
            `WDG_ADDR_LOW:        rdata_o <= reload_low_byte_reg;
            `WDG_ADDR_CONFIG:     rdata_o <= {6'h00, on_reg, cfg_irq_reg};
            `WDG_ADDR_IRQ_STATUS: rdata_o <= {7'h00, irq_stat_reg};
            `WDG_ADDR_IRQ_MASK:   rdata_o <= {7'h00, irq_mask_reg};
            `WDG_ADDR_COUNT_U:    rdata_o <= count_reg[23:16];
            default:              rdata_o <= 8'h00;
         endcase
      end else
         rdata_o <= 8'h00;
   end
endmodule
`default_nettype wire

/* tb/watchdog_checker.sv */
// Purpose: port-level assertions for the 24-bit watchdog
// Assumes: one clock, synchronous active-high reset
// Notes:   sees only top-level ports, attached by bind
`timescale 1ns/1ps
`default_nettype none
module watchdog_checker (
   // clock and reset
   input wire logic       clk_sys_i,
   input wire logic       rst_i,
   // register port
   input wire logic       rd_i,
   input wire logic [7:0] rdata_o,
   // device side
   input wire logic       refresh_i,
   input wire logic       always_on_option_bit_i,
   input wire logic       wdt_reset_o,
   input wire logic       irq_o,
   input wire logic       running_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   // ----------------------------------------------------------------
   // sequences
   // ----------------------------------------------------------------
   // a started watchdog is seen on in two successive cycles
   sequence s_run_two;
      running_o ##1 running_o;
   endsequence
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_rdata_idle_zero: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
      else $error("read data not zero outside read answer cycle");
   a_run_no_stop: assert property (running_o |=> running_o)
      else $error("watchdog stopped while on");
   a_refresh_starts: assert property (refresh_i |=> s_run_two)
      else $error("refresh did not switch watchdog on");
   a_always_on_start: assert property ($past(rst_i) && always_on_option_bit_i |=> running_o)
      else $error("always-on bit did not start watchdog after reset");
   a_off_stays_off: assert property (!running_o && !refresh_i && !$past(rst_i) |=> !running_o)
      else $error("watchdog switched on without cause");
   a_rst_one_pulse: assert property (wdt_reset_o |=> !wdt_reset_o)
      else $error("reset request longer than one cycle");
   a_rst_when_run: assert property (wdt_reset_o |-> $past(running_o))
      else $error("reset request while watchdog off");
   a_irq_when_run: assert property (irq_o |-> running_o)
      else $error("interrupt while watchdog off");
endmodule
bind watchdog_timer_24bit watchdog_checker i_chk (
   .clk_sys_i              (clk_sys_i),
   .rst_i                  (rst_i),
   .rd_i                   (rd_i),
   .rdata_o                (rdata_o),
   .refresh_i              (refresh_i),
   .always_on_option_bit_i (always_on_option_bit_i),
   .wdt_reset_o            (wdt_reset_o),
   .irq_o                  (irq_o),
   .running_o              (running_o)
);
`default_nettype wire

/* tb/tb_top.sv */
// Purpose: self-checking bench for the 24-bit watchdog
// Assumes: tick divider shortened to 4 clocks
// Notes:   reload of 8 gives a time-out near 32 clocks
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_defs.vh"
module tb_top;
   logic        clk_sys_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [11:0] addr_i = 12'h000;
   logic [7:0]  wdata_i = 8'h00;
   logic        wr_i = 1'b0;
   logic        rd_i = 1'b0;
   logic        refresh_i = 1'b0;
   logic        ao_bit = 1'b0;
   logic [7:0]  rdata_o;
   logic        wdt_reset_o;
   logic        irq_o;
   logic        running_o;
   int          miscompares = 0;
   int          num_checks = 0;
   int          cyc = 0;
   int          n;
   // ----------------------------------------------------------------
   // clock, device and hang guard
   // ----------------------------------------------------------------
   // 200 MHz system clock
   always #2.5 clk_sys_i = ~clk_sys_i;
   watchdog_timer_24bit #(.TICK_DIVIDE(4)) i_dut (
      .clk_sys_i              (clk_sys_i),
      .rst_i                  (rst_i),
      .addr_i                 (addr_i),
      .wdata_i                (wdata_i),
      .wr_i                   (wr_i),
      .rd_i                   (rd_i),
      .rdata_o                (rdata_o),
      .refresh_i              (refresh_i),
      .always_on_option_bit_i (ao_bit),
      .wdt_reset_o            (wdt_reset_o),
      .irq_o                  (irq_o),
      .running_o              (running_o)
   );
   // whole run is well under 2000 clocks, so 5000 means a hang
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 5000) begin
         miscompares++;
         test_done();
      end
   end
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [11:0] a, input logic [7:0] exp, input string nm);
      @(posedge clk_sys_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_sys_i);
      rd_i <= 1'b0;
      #1;
      chk(nm, rdata_o, exp);
   endtask
   task automatic refresh();
      @(posedge clk_sys_i);
      refresh_i <= 1'b1;
      @(posedge clk_sys_i);
      refresh_i <= 1'b0;
   endtask
   task automatic reset_dut();
      rst_i <= 1'b1;
      repeat (6) @(posedge clk_sys_i);
      rst_i <= 1'b0;
   endtask
   // bounded wait for an output to go high, n counts clocks
   task automatic wait_hi(input bit use_irq);
      n = 0;
      while (((use_irq ? irq_o : wdt_reset_o) !== 1'b1) && n < 80) begin
         @(posedge clk_sys_i);
         #1;
         n++;
      end
   endtask
   task automatic test_done();
      if (miscompares == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      reset_dut();
      rd(`WDG_ADDR_UPPER, 8'h00, "reload upper");
      rd(`WDG_ADDR_HIGH, 8'h04, "reload high");
      rd(`WDG_ADDR_LOW, 8'h00, "reload low");
      rd(`WDG_ADDR_CONFIG, 8'h00, "config idle");
      rd(12'h0FF8, 8'h00, "unmapped");
      wr(`WDG_ADDR_HIGH, 8'h77);
      rd(`WDG_ADDR_HIGH, 8'h04, "locked high");
      wr(`WDG_ADDR_CONTROL, `WDG_KEY_FIRST);
      wr(`WDG_ADDR_CONTROL, `WDG_KEY_SECOND);
      wr(`WDG_ADDR_HIGH, 8'h00);
      wr(`WDG_ADDR_LOW, 8'h08);
      wr(`WDG_ADDR_HIGH, 8'h33);
      rd(`WDG_ADDR_HIGH, 8'h00, "relocked high");
      rd(`WDG_ADDR_LOW, 8'h08, "reload low new");
      rd(`WDG_ADDR_CONTROL, 8'h00, "reset status");
      wr(`WDG_ADDR_CONTROL, `WDG_KEY_FIRST);
      wr(`WDG_ADDR_CONTROL, 8'h12);
      wr(`WDG_ADDR_CONTROL, `WDG_KEY_SECOND);
      wr(`WDG_ADDR_LOW, 8'h20);
      rd(`WDG_ADDR_LOW, 8'h08, "broken unlock");
      // interrupt mode, unmasked, then time-out from reload 8
      wr(`WDG_ADDR_CONFIG, 8'h01);
      wr(`WDG_ADDR_IRQ_MASK, 8'h01);
      refresh();
      rd(`WDG_ADDR_CONFIG, 8'h03, "running bit");
      wait_hi(1'b1);
      chk("timeout window", 8'((n >= 24 && n <= 34) ? 1 : 0), 8'h01);
      wr(`WDG_ADDR_IRQ_STATUS, 8'h01);
      // look after the clearing edge has settled
      #1;
      chk("irq cleared", {7'h0, irq_o}, 8'h00);
      wr(`WDG_ADDR_IRQ_MASK, 8'h00);
      repeat (40) @(posedge clk_sys_i);
      rd(`WDG_ADDR_IRQ_STATUS, 8'h01, "masked status");
      chk("irq masked", {7'h0, irq_o}, 8'h00);
      wr(`WDG_ADDR_IRQ_MASK, 8'h01);
      #1;
      chk("irq unmasked", {7'h0, irq_o}, 8'h01);
      wr(`WDG_ADDR_IRQ_STATUS, 8'h01);
      // steady refreshing keeps the time-out away
      repeat (8) begin
         refresh();
         repeat (14) @(posedge clk_sys_i);
      end
      rd(`WDG_ADDR_IRQ_STATUS, 8'h00, "refreshed");
      // reset mode: one pulse, then status read clears itself
      wr(`WDG_ADDR_CONFIG, 8'h00);
      wait_hi(1'b0);
      chk("reset pulse", {7'h0, wdt_reset_o}, 8'h01);
      rd(`WDG_ADDR_CONTROL, 8'h01, "status set");
      rd(`WDG_ADDR_CONTROL, 8'h00, "status cleared");
      // align on a pulse, then refresh while the count stands at two
      wait_hi(1'b0);
      repeat (24) @(posedge clk_sys_i);
      refresh();
      wait_hi(1'b0);
      chk("late refresh", 8'((n <= 8) ? 1 : 0), 8'h01);
      @(posedge clk_sys_i);
      ao_bit <= 1'b1;
      reset_dut();
      repeat (3) @(posedge clk_sys_i);
      chk("always on", {7'h0, running_o}, 8'h01);
      // upper byte reaches the counter through a refresh
      wr(`WDG_ADDR_CONTROL, `WDG_KEY_FIRST);
      wr(`WDG_ADDR_CONTROL, `WDG_KEY_SECOND);
      wr(`WDG_ADDR_UPPER, 8'h01);
      wr(`WDG_ADDR_LOW, 8'h00);
      refresh();
      rd(`WDG_ADDR_COUNT_U, 8'h01, "count upper");
      test_done();
   end
endmodule
`default_nettype wire
